//--- design/bldc_drive_map.svh
`ifndef BLDC_DRIVE_MAP_SVH
`define BLDC_DRIVE_MAP_SVH
// Register byte addresses
`define REG_STATUS 8'h00
`define REG_IRQ_STAT 8'h04
`define REG_IRQ_MASK 8'h08
`define REG_CAP_UF 8'h0c
`define REG_SPEED 8'h10
`define REG_DUTY 8'h14
// Status field positions
`define ST_LOCK 0
`define ST_SAVE 1
`define ST_TRIP 2
`define ST_BRAKE 3
`define ST_DIR 4
`define ST_HALL 5
`define ST_LDPIN 8
// Interrupt event bit positions
`define EV_LOCK_GAIN 0
`define EV_LOCK_LOSS 1
`define EV_TRIP 2
`define EV_BRAKE 3
`define EV_CURLIM 4
`define EV_W 5
// Reset values
`define CAP_RST 8'h00
`define MASK_RST 5'h00
`define SYNC_RST 8'h98
// Timing
`define CLK_HZ 125000000
`define REF_DIV 8192
`define PWM_HZ 20000
`define PWM_PERIOD_CYC (`CLK_HZ / `PWM_HZ)
`define MS_CYC (`CLK_HZ / 1000)
`define RESTRAINT_MS_PER_UF 330
`define STOP_MS_PER_UF 15
`define LOCK_SHIFT 4
`define GAIN_SHIFT 4
`endif

//--- design/bldc_drive_pkg.sv
package bldc_drive_pkg;
    // Drive state
    typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_BRAKE, ST_TRIPPED} driveState_t;
    // One bit per motor phase
    typedef logic [2:0] phase_t;
endpackage

//--- design/bldc_drive_protection_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "bldc_drive_map.svh"
module bldc_drive_protection_control
    import bldc_drive_pkg::*;
#(
    parameter int REF_DIV = `REF_DIV,
    parameter int PWM_PERIOD = `PWM_PERIOD_CYC,
    parameter int MS_CYCLES = `MS_CYC,
    parameter int GAIN_SHIFT = `GAIN_SHIFT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq,
    // Motor and host pins
    input wire logic [2:0] hallIn,
    input wire logic runStop,
    input wire logic dirReverse,
    input wire logic tachoPulse,
    input wire logic currentSenseTrip,
    // Drive outputs
    output phase_t lowSideOn,
    output phase_t highSideOn,
    output logic powerSave,
    output logic internalRegulatorOn,
    // Open-drain lock indicator
    input wire logic speedLockIndicatorNIn,
    output logic speedLockIndicatorNOut,
    output logic speedLockIndicatorNOe
);

////////////////////////////////////////////////////////////////////////////////
// Constants
localparam logic [15:0] TARGET = 16'(2 * REF_DIV);
localparam logic [15:0] BAND = TARGET >> `LOCK_SHIFT;
localparam logic [16:0] SLOW_LIM = {1'b0, TARGET} + {1'b0, BAND};
localparam logic [15:0] REF_TOP = 16'(REF_DIV - 1);
localparam logic [15:0] REF_HALF = 16'(REF_DIV / 2);
localparam logic [15:0] PWM_TOP = 16'(PWM_PERIOD - 1);
localparam logic [15:0] DUTY_START = 16'(PWM_PERIOD / 2);
localparam logic [16:0] MS_TOP = 17'(MS_CYCLES - 1);
localparam logic [19:0] DECAY =
    20'(`RESTRAINT_MS_PER_UF / `STOP_MS_PER_UF);
localparam logic [7:0] SYNC_INIT = `SYNC_RST;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
logic [7:0] pinRaw; // Raw pins
logic [7:0] s1Q, s2Q, s3Q; // Three stages
logic [7:0] pinQ, pinD; // Agreed levels
assign pinRaw = {speedLockIndicatorNIn, currentSenseTrip, tachoPulse,
                 dirReverse, runStop, hallIn};
generate
    for (genvar i = 0; i < 8; i++) begin : g_sync
        // Accept a change once stages two and three agree
        always_comb begin
            pinD[i] = (s2Q[i] == s3Q[i]) ? s3Q[i] : pinQ[i];
        end
        // Shift stages
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                s1Q[i] <= SYNC_INIT[i];
                s2Q[i] <= SYNC_INIT[i];
                s3Q[i] <= SYNC_INIT[i];
                pinQ[i] <= SYNC_INIT[i];
            end else begin
                s1Q[i] <= pinRaw[i];
                s2Q[i] <= s1Q[i];
                s3Q[i] <= s2Q[i];
                pinQ[i] <= pinD[i];
            end
        end
    end
endgenerate
logic [2:0] hall; // Hall comparator code
logic stopSel, dirRev, tacho, oc, ldPin;
assign hall = pinQ[2:0];
assign stopSel = pinQ[3];
assign dirRev = pinQ[4];
assign tacho = pinQ[5];
assign oc = pinQ[6];
assign ldPin = pinQ[7];

////////////////////////////////////////////////////////////////////////////////
// Commutation
// Returns {high, low}; reverse swaps the sides
function automatic logic [5:0] commute(input logic [2:0] h, input logic rev);
    logic [5:0] c;
    c = 6'h00;
    unique case (h)
        3'b101: c = {3'b001, 3'b010};
        3'b100: c = {3'b001, 3'b100};
        3'b110: c = {3'b010, 3'b100};
        3'b010: c = {3'b010, 3'b001};
        3'b011: c = {3'b100, 3'b001};
        3'b001: c = {3'b100, 3'b010};
        default: c = 6'h00;
    endcase
    return rev ? {c[2:0], c[5:3]} : c;
endfunction

////////////////////////////////////////////////////////////////////////////////
// Drive state
driveState_t stateQ, stateD; // Drive state
logic tachoPrevQ, tachoPrevD; // Tacho edge detect
logic halfQ, halfD; // Second tacho edge marker
logic [15:0] periodQ, periodD; // Cycles over two tacho periods
logic [15:0] speedQ, speedD; // Last measurement
logic [15:0] phaseQ, phaseD; // Reference phase counter
logic [15:0] phaseDevQ, phaseDevD; // Phase error
logic lockQ, lockD; // In lock band
logic [15:0] dutyQ, dutyD; // On-time in cycles
logic [15:0] pwmCntQ, pwmCntD; // Carrier counter
logic cutQ, cutD; // Current limit cut
logic dirPrevQ, dirPrevD; // Last direction
logic dirChgQ, dirChgD; // Reversal in progress
logic [16:0] msDivQ, msDivD; // Millisecond divider
logic [19:0] rcntQ, rcntD; // Restraint charge in ms
logic [7:0] capQ, capD; // Timer capacitance in uF
phase_t lowQ, lowD, highQ, highD; // Transistor drive
logic ldOeQ, ldOeD; // Lock indicator pull
logic psQ, psD; // Power save
logic tachoEdge, measDone, inBand, wrap, pwmOn, trip;
logic signed [16:0] devM, devSh; // Speed deviation
logic [16:0] absDev; // Its magnitude
logic signed [17:0] sumS; // Corrected duty
logic [19:0] tripLim; // Restraint interval in ms
logic [5:0] comm; // Commutation pattern
logic [`EV_W-1:0] ev; // Event pulses

// Next drive state
always_comb begin
    tachoEdge = tacho & ~tachoPrevQ;
    tachoPrevD = tacho;
    // Two-period speed measurement
    periodD = (periodQ == 16'hffff) ? periodQ : periodQ + 16'h0001;
    halfD = halfQ;
    speedD = speedQ;
    measDone = 1'b0;
    if (tachoEdge) begin
        halfD = ~halfQ;
        if (halfQ) begin
            speedD = periodQ;
            periodD = 16'h0000;
            measDone = 1'b1;
        end
    end
    devM = $signed({1'b0, periodQ}) - $signed({1'b0, TARGET});
    absDev = devM[16] ? 17'(-devM) : 17'(devM);
    inBand = absDev <= {1'b0, BAND};
    // Phase loop, one result per tacho cycle
    phaseD = (phaseQ == REF_TOP) ? 16'h0000 : phaseQ + 16'h0001;
    phaseDevD = tachoEdge ? phaseQ - REF_HALF : phaseDevQ;
    // Lock window
    lockD = lockQ;
    if (measDone) begin
        lockD = inBand;
    end
    if ({1'b0, periodQ} > SLOW_LIM) begin
        lockD = 1'b0;
    end
    // Duty correction
    devSh = devM >>> GAIN_SHIFT;
    sumS = $signed({2'b00, dutyQ}) + $signed({devSh[16], devSh});
    dutyD = dutyQ;
    if (measDone && !inBand) begin
        if (sumS < 0) begin
            dutyD = 16'h0000;
        end else if (sumS > $signed({2'b00, PWM_TOP})) begin
            dutyD = PWM_TOP;
        end else begin
            dutyD = sumS[15:0];
        end
    end else if (tachoEdge && lockQ) begin
        // Early edge means fast rotation
        if (phaseQ < REF_HALF && dutyQ != 16'h0000) begin
            dutyD = dutyQ - 16'h0001;
        end else if (phaseQ >= REF_HALF && dutyQ < PWM_TOP) begin
            dutyD = dutyQ + 16'h0001;
        end
    end
    // Carrier and cycle-by-cycle limit
    wrap = pwmCntQ == PWM_TOP;
    pwmCntD = wrap ? 16'h0000 : pwmCntQ + 16'h0001;
    cutD = wrap ? 1'b0 : cutQ;
    if (oc) begin
        cutD = 1'b1;
    end
    pwmOn = (pwmCntD < dutyD) && !cutD;
    // Reversal tracking
    dirPrevD = dirRev;
    dirChgD = dirChgQ;
    if (stopSel) begin
        dirChgD = 1'b0;
    end else if (dirRev != dirPrevQ) begin
        dirChgD = 1'b1;
    end else if (lockD && !lockQ) begin
        // Reversal window closes when lock is regained or stop is selected
        dirChgD = 1'b0;
    end
    // Restraint timer
    msDivD = (msDivQ == MS_TOP) ? 17'h00000 : msDivQ + 17'h00001;
    tripLim = 20'(capQ) * 20'(`RESTRAINT_MS_PER_UF);
    trip = (capQ != 8'h00) && (rcntQ >= tripLim);
    rcntD = rcntQ;
    if (stopSel) begin
        // Charge bleeds off while stopped
        if (msDivQ == MS_TOP) begin
            rcntD = (rcntQ > DECAY) ? rcntQ - DECAY : 20'h00000;
        end
    end else if (stateQ == ST_TRIPPED) begin
        rcntD = rcntQ;
    end else if (lockQ) begin
        rcntD = 20'h00000;
    end else if (msDivQ == MS_TOP && rcntQ != 20'hfffff) begin
        rcntD = rcntQ + 20'h00001;
    end
    // State sequence
    stateD = stateQ;
    unique case (stateQ)
        ST_STOP: begin
            stateD = ST_RUN;
        end
        ST_RUN: begin
            if (dirChgQ && oc) begin
                stateD = ST_BRAKE;
            end else if (trip) begin
                stateD = ST_TRIPPED;
            end
        end
        ST_BRAKE: begin
            if (trip) begin
                stateD = ST_TRIPPED;
            end else if (wrap && !oc) begin
                stateD = ST_RUN;
            end
        end
        ST_TRIPPED: begin
            stateD = ST_TRIPPED;
        end
    endcase
    if (stopSel) begin
        stateD = ST_STOP;
        lockD = 1'b0;
        dutyD = DUTY_START;
    end
    // Transistor drive
    comm = commute(hall, dirRev);
    highD = 3'b000;
    lowD = 3'b000;
    if (stateD == ST_RUN) begin
        highD = comm[5:3];
        lowD = comm[2:0] & {3{pwmOn}};
    end else if (stateD == ST_BRAKE) begin
        highD = 3'b111;
    end
    ldOeD = lockD;
    psD = stateD == ST_STOP;
    // Events
    ev = '0;
    ev[`EV_LOCK_GAIN] = lockD & ~lockQ;
    ev[`EV_LOCK_LOSS] = ~lockD & lockQ;
    ev[`EV_TRIP] = (stateD == ST_TRIPPED) && (stateQ != ST_TRIPPED);
    ev[`EV_BRAKE] = (stateD == ST_BRAKE) && (stateQ != ST_BRAKE);
    ev[`EV_CURLIM] = oc && !cutQ && (stateQ == ST_RUN);
end

// Register drive state
always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        stateQ <= ST_STOP;
        tachoPrevQ <= 1'b0;
        halfQ <= 1'b0;
        periodQ <= 16'h0000;
        speedQ <= 16'h0000;
        phaseQ <= 16'h0000;
        phaseDevQ <= 16'h0000;
        lockQ <= 1'b0;
        dutyQ <= DUTY_START;
        pwmCntQ <= 16'h0000;
        cutQ <= 1'b0;
        dirPrevQ <= 1'b1;
        dirChgQ <= 1'b0;
        msDivQ <= 17'h00000;
        rcntQ <= 20'h00000;
        lowQ <= 3'b000;
        highQ <= 3'b000;
        ldOeQ <= 1'b0;
        psQ <= 1'b1;
    end else begin
        stateQ <= stateD;
        tachoPrevQ <= tachoPrevD;
        halfQ <= halfD;
        periodQ <= periodD;
        speedQ <= speedD;
        phaseQ <= phaseD;
        phaseDevQ <= phaseDevD;
        lockQ <= lockD;
        dutyQ <= dutyD;
        pwmCntQ <= pwmCntD;
        cutQ <= cutD;
        dirPrevQ <= dirPrevD;
        dirChgQ <= dirChgD;
        msDivQ <= msDivD;
        rcntQ <= rcntD;
        lowQ <= lowD;
        highQ <= highD;
        ldOeQ <= ldOeD;
        psQ <= psD;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Wishbone registers and interrupt
logic [`EV_W-1:0] statQ, statD, maskQ, maskD; // Sticky events and mask
logic irqQ, irqD; // Interrupt level
logic ackQ, ackD; // Bus acknowledge
logic [31:0] datQ, datD; // Read data
logic hit, wr; // Decoded access
logic [7:0] adr; // Word-aligned address

// Next register values
always_comb begin
    adr = {adr_i[7:2], 2'b00};
    hit = cyc_i && stb_i && !ackQ;
    // Writes land at the edge where the master samples ack
    wr = cyc_i && stb_i && ackQ && we_i && sel_i[0];
    capD = (wr && adr == `REG_CAP_UF) ? dat_i[7:0] : capQ;
    maskD = (wr && adr == `REG_IRQ_MASK) ? dat_i[`EV_W-1:0] : maskQ;
    // New events win over a clearing write
    statD = statQ;
    if (wr && adr == `REG_IRQ_STAT) begin
        statD = statQ & ~dat_i[`EV_W-1:0];
    end
    statD = statD | ev;
    irqD = |(statD & maskD);
    ackD = hit;
    datD = 32'h00000000;
    if (hit && !we_i) begin
        unique case (adr)
            `REG_STATUS: begin
                datD[`ST_LOCK] = lockQ;
                datD[`ST_SAVE] = psQ;
                datD[`ST_TRIP] = stateQ == ST_TRIPPED;
                datD[`ST_BRAKE] = stateQ == ST_BRAKE;
                datD[`ST_DIR] = dirRev;
                datD[`ST_HALL +: 3] = hall;
                datD[`ST_LDPIN] = ldPin;
            end
            `REG_IRQ_STAT: datD[`EV_W-1:0] = statQ;
            `REG_IRQ_MASK: datD[`EV_W-1:0] = maskQ;
            `REG_CAP_UF: datD[7:0] = capQ;
            `REG_SPEED: datD = {phaseDevQ, speedQ};
            `REG_DUTY: datD[15:0] = dutyQ;
            default: datD = 32'h00000000;
        endcase
    end
end

// Register bus state
always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        capQ <= `CAP_RST;
        maskQ <= `MASK_RST;
        statQ <= '0;
        irqQ <= 1'b0;
        ackQ <= 1'b0;
        datQ <= 32'h00000000;
    end else begin
        capQ <= capD;
        maskQ <= maskD;
        statQ <= statD;
        irqQ <= irqD;
        ackQ <= ackD;
        datQ <= datD;
    end
end

assign dat_o = datQ;
assign ack_o = ackQ;
assign irq = irqQ;
assign lowSideOn = lowQ;
assign highSideOn = highQ;
assign powerSave = psQ;
assign internalRegulatorOn = rst_b | ~rst_b;
assign speedLockIndicatorNOut = 1'b0;
assign speedLockIndicatorNOe = ldOeQ;

////////////////////////////////////////////////////////////////////////////////
// Assertions
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_b);
logic lowSide_zero; // Low sides off or stop selected
assign lowSide_zero = (lowSideOn == 3'b000) || stopSel;

sequence s_revCur;
    stateQ == ST_RUN && dirChgQ && oc && !stopSel;
endsequence
sequence s_braked;
    stateQ == ST_BRAKE && highSideOn == 3'b111 && lowSideOn == 3'b000;
endsequence

property p_stop_save;
    stopSel |=> powerSave && lowSideOn == 3'b000 && highSideOn == 3'b000;
endproperty
a_stop_save: assert property (p_stop_save) else $error("stop not saving");
property p_cur_cut;
    (oc && stateQ == ST_RUN) |=> lowSideOn == 3'b000;
endproperty
a_cur_cut: assert property (p_cur_cut) else $error("no current cut");
property p_low_pwm;
    (lowSideOn != 3'b000) |-> (highSideOn != 3'b000) && !(|(lowSideOn & highSideOn));
endproperty
a_low_pwm: assert property (p_low_pwm) else $error("bad drive pattern");
property p_lock;
    (measDone && !stopSel) |=> speedLockIndicatorNOe == $past(inBand);
endproperty
a_lock: assert property (p_lock) else $error("lock pin wrong");
property p_duty_up;
    (measDone && !inBand && !devM[16] && dutyQ < PWM_TOP && !stopSel)
        |=> dutyQ > $past(dutyQ);
endproperty
a_duty_up: assert property (p_duty_up) else $error("duty not raised");
property p_rev_brake;
    s_revCur |=> s_braked;
endproperty
a_rev_brake: assert property (p_rev_brake) else $error("no short brake");
property p_trip;
    (stateQ == ST_RUN && !stopSel && trip && !(dirChgQ && oc))
        |=> stateQ == ST_TRIPPED ##1 lowSide_zero;
endproperty
a_trip: assert property (p_trip) else $error("restraint missed");
property p_hold;
    (stateQ == ST_TRIPPED && !stopSel) |=> stateQ == ST_TRIPPED;
endproperty
a_hold: assert property (p_hold) else $error("trip released");
property p_no_trip;
    (capQ == 8'h00 && stateQ != ST_TRIPPED) |=> stateQ != ST_TRIPPED;
endproperty
a_no_trip: assert property (p_no_trip) else $error("trip at zero cap");

endmodule // bldc_drive_protection_control
`default_nettype wire

//--- verif/bldc_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module bldc_motor_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bench controls
    input wire logic spin,
    input wire logic reverse,
    input wire logic [15:0] halfPeriod,
    input wire logic overload,
    // Sensor outputs
    output logic [2:0] hall,
    output logic tacho,
    output logic senseTrip
);
    ////////////////////////////////////////////////////////////////////////////
    // Rotor position and tacho half-period counter
    logic [2:0] stepQ;
    logic [15:0] cntQ;

    // Forward Hall order; reverse rotation walks it backwards
    function automatic logic [2:0] code(input logic [2:0] i);
        case (i)
            3'h0: code = 3'h5;
            3'h1: code = 3'h4;
            3'h2: code = 3'h6;
            3'h3: code = 3'h2;
            3'h4: code = 3'h3;
            default: code = 3'h1;
        endcase
    endfunction

    // Rotor advances one step per tacho half period; a stalled rotor stands still
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stepQ <= 3'h0;
            cntQ <= 16'h0000;
            tacho <= 1'h0;
        end else if (spin) begin
            if (cntQ + 16'h0001 >= halfPeriod) begin
                cntQ <= 16'h0000;
                tacho <= ~tacho;
                if (reverse) begin
                    stepQ <= (stepQ == 3'h0) ? 3'h5 : stepQ - 3'h1;
                end else begin
                    stepQ <= (stepQ == 3'h5) ? 3'h0 : stepQ + 3'h1;
                end
            end else begin
                cntQ <= cntQ + 16'h0001;
            end
        end
    end

    assign hall = code(stepQ);
    // Sense voltage at threshold only when the bench commands an overload
    assign senseTrip = overload;
endmodule // bldc_motor_model
`default_nettype wire

//--- verif/bldc_drive_protection_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "bldc_drive_map.svh"
module bldc_drive_protection_control_bench;
    import bldc_drive_pkg::*;
    // Scaled counts keep the run short
    localparam int REF = 256;
    localparam int MSC = 4;
    ////////////////////////////////////////////////////////////////////////////
    // Bench signals
    logic clk = 1'h0;
    logic rstB = 1'h0;
    logic cycI = 1'h0;
    logic stbI = 1'h0;
    logic weI = 1'h0;
    logic [7:0] adrI = 8'h00;
    logic [31:0] datI = 32'h0;
    logic [31:0] datO, rd, d1;
    logic ackO, irq, tachoPulse, senseTrip, powerSave, regOn, ldOut, ldOe, ldPin;
    logic runStop = 1'h1;
    logic dirReverse = 1'h0;
    logic spin = 1'h0;
    logic overload = 1'h0;
    logic [15:0] halfPer = 16'h0080;
    logic [2:0] hallIn;
    phase_t lowSideOn, highSideOn;
    phase_t fwdHs [8];
    int errCount = 0;
    int checksDone = 0;
    int cycles = 0;
    int diff;

    // 125 MHz clock; the reference is a clean on-chip source
    always #4 clk = ~clk;
    // Pull-up on the open-drain lock pin
    assign ldPin = ldOe ? ldOut : 1'h1;

    bldc_drive_protection_control #(.REF_DIV(REF), .PWM_PERIOD(100), .MS_CYCLES(MSC))
        i_bldc_drive_protection_control (
        .clk(clk), .rst_b(rstB), .cyc_i(cycI), .stb_i(stbI), .we_i(weI), .adr_i(adrI),
        .sel_i(4'hf), .dat_i(datI), .dat_o(datO), .ack_o(ackO), .irq(irq),
        .hallIn(hallIn), .runStop(runStop), .dirReverse(dirReverse),
        .tachoPulse(tachoPulse), .currentSenseTrip(senseTrip), .lowSideOn(lowSideOn),
        .highSideOn(highSideOn), .powerSave(powerSave), .internalRegulatorOn(regOn),
        .speedLockIndicatorNIn(ldPin), .speedLockIndicatorNOut(ldOut),
        .speedLockIndicatorNOe(ldOe));

    bldc_motor_model i_bldc_motor_model (
        .clk(clk), .rst_b(rstB), .spin(spin), .reverse(dirReverse), .halfPeriod(halfPer),
        .overload(overload), .hall(hallIn), .tacho(tachoPulse), .senseTrip(senseTrip));

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checksDone++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cycI <= 1'h1;
        stbI <= 1'h1;
        weI <= w;
        adrI <= a;
        datI <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ackO !== 1'h1 && n < 50);
        r = datO;
        if (n >= 50) chk(0, 1, "bus ack missing");
        cycI <= 1'h0;
        stbI <= 1'h0;
        weI <= 1'h0;
    endtask

    // Run cycles; mode 1 records high sides per Hall code, mode 2 checks reversal
    task automatic step(input int n, input int mode);
        logic [2:0] last;
        int stab;
        last = hallIn;
        stab = 0;
        repeat (n) begin
            @(posedge clk);
            chk(32'(lowSideOn & highSideOn), 0, "both sides of a phase on");
            stab = (hallIn === last) ? stab + 1 : 0;
            last = hallIn;
            if (stab == 8 && mode == 1) fwdHs[hallIn] = highSideOn;
            if (stab == 8 && mode == 2) chk(32'(highSideOn), 32'(fwdHs[~hallIn]), "rev order");
        end
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            errCount++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(13));
        repeat (12) @(posedge clk);
        rstB <= 1'h1;
        chk(powerSave, 1, "power save in stop");
        chk(regOn, 1, "regulator alive");
        chk(32'(lowSideOn), 0, "low sides idle");
        wb(1'h0, `REG_IRQ_MASK, 32'h0, rd);
        chk(rd, 0, "mask reset");
        wb(1'h0, `REG_CAP_UF, 32'h0, rd);
        chk(rd, 0, "cap reset");
        wb(1'h0, 8'h18, 32'h0, rd);
        chk(rd, 0, "unmapped read");
        d1 = 32'($urandom % 32);
        wb(1'h1, `REG_IRQ_MASK, d1, rd);
        wb(1'h0, `REG_IRQ_MASK, 32'h0, rd);
        chk(rd, d1, "mask readback");
        wb(1'h1, `REG_IRQ_MASK, 32'h0, rd);
        // On-speed forward run at a random period inside the band
        halfPer <= 16'(126 + $urandom % 5);
        spin <= 1'h1;
        runStop <= 1'h0;
        step(3200, 1);
        chk(powerSave, 0, "running");
        chk(ldOe, 1, "lock shown");
        wb(1'h0, `REG_STATUS, 32'h0, rd);
        chk(rd[`ST_LOCK], 1, "lock status");
        chk(rd[`ST_LDPIN], 0, "pin low when locked");
        wb(1'h0, `REG_SPEED, 32'h0, rd);
        diff = int'(rd[15:0]) - 4 * int'(halfPer);
        chk(32'(diff <= 2 && diff >= -2), 1, "two-period count");
        // Direction flip while turning
        dirReverse <= 1'h1;
        step(1600, 2);
        wb(1'h0, `REG_STATUS, 32'h0, rd);
        chk(rd[`ST_DIR], 1, "direction status");
        // Slow motor: unlocked, duty rises; fast motor: duty falls
        halfPer <= 16'h0096;
        step(2400, 0);
        chk(ldOe, 0, "lock released");
        wb(1'h0, `REG_DUTY, 32'h0, rd);
        d1 = rd;
        step(1200, 0);
        wb(1'h0, `REG_DUTY, 32'h0, rd);
        chk(32'(rd > d1 || rd == 99), 1, "duty up when slow");
        halfPer <= 16'h006e;
        d1 = rd;
        step(1800, 0);
        wb(1'h0, `REG_DUTY, 32'h0, rd);
        chk(32'(rd < d1 || rd == 0), 1, "duty down when fast");
        // Current limit with its interrupt
        halfPer <= 16'h0080;
        step(2400, 0);
        wb(1'h1, `REG_IRQ_MASK, 32'h10, rd);
        overload <= 1'h1;
        step(9, 0);
        chk(32'(lowSideOn), 0, "low sides cut");
        chk(irq, 1, "limit irq");
        overload <= 1'h0;
        step(200, 0);
        wb(1'h1, `REG_IRQ_STAT, 32'h10, rd);
        step(2, 0);
        chk(irq, 0, "irq cleared");
        wb(1'h0, `REG_IRQ_STAT, 32'h0, rd);
        chk(rd[`EV_CURLIM], 0, "status cleared");
        // Direction change then overcurrent: short brake
        dirReverse <= 1'h0;
        step(20, 0);
        overload <= 1'h1;
        step(10, 0);
        wb(1'h0, `REG_STATUS, 32'h0, rd);
        chk(rd[`ST_BRAKE], 1, "brake entered");
        chk(32'(lowSideOn), 0, "low sides off in brake");
        overload <= 1'h0;
        // Unlocked run with grounded timer capacitor never trips
        halfPer <= 16'h0096;
        step(4000, 0);
        wb(1'h0, `REG_STATUS, 32'h0, rd);
        chk(rd[`ST_TRIP], 0, "no trip with cap zero");
        wb(1'h1, `REG_CAP_UF, 32'h1, rd);
        wb(1'h1, `REG_IRQ_MASK, 32'h4, rd);
        // Stop held well past 15 ms per uF before restart
        runStop <= 1'h1;
        step(400, 0);
        runStop <= 1'h0;
        step(1100, 0);
        wb(1'h0, `REG_STATUS, 32'h0, rd);
        chk(rd[`ST_TRIP], 0, "not yet tripped");
        step(500, 0);
        wb(1'h0, `REG_STATUS, 32'h0, rd);
        chk(rd[`ST_TRIP], 1, "tripped");
        chk(irq, 1, "trip irq");
        repeat (200) begin
            step(1, 0);
            chk(32'(lowSideOn), 0, "low sides held off");
        end
        runStop <= 1'h1;
        step(20, 0);
        wb(1'h0, `REG_STATUS, 32'h0, rd);
        chk(rd[`ST_TRIP], 0, "stop releases trip");
        chk(powerSave, 1, "power save again");
        end_sim();
    end
endmodule // bldc_drive_protection_control_bench
`default_nettype wire
